// >>> src/pgr_pkg.sv
package pgr_pkg;

	// ----------------------------------------
	// Memory module temperature table
	// ----------------------------------------
	localparam int unsigned MOD_COUNT = 8;
	localparam int unsigned TEMP_W    = 8;

	// ----------------------------------------
	// Reset values of the pins and controls
	// ----------------------------------------
	localparam logic SYNC_RST_VAL       = 1'h0;
	localparam logic TRIP_N_RST_VAL     = 1'h1;
	localparam logic CORE_RST_RST_VAL   = 1'h1;
	localparam logic INVAL_RST_VAL      = 1'h1;
	localparam logic STICKY_RST_RST_VAL = 1'h1;
	localparam logic HALT_RST_VAL       = 1'h0;
	localparam logic PLL_OFF_RST_VAL    = 1'h0;
	localparam logic CAUSE_RST_VAL      = 1'h0;
	localparam logic SEEN_RST_VAL       = 1'h0;
	localparam int unsigned SCAN_START  = 32'h0;

	// ----------------------------------------
	// Memory content at reset
	// ----------------------------------------
	localparam logic [7:0] TEMP_RST_VAL = 8'h00;

endpackage

// >>> src/pgr_temp_mem.sv
`timescale 1ns/100ps
module pgr_temp_mem #(
	parameter int unsigned DEPTH = pgr_pkg::MOD_COUNT,
	parameter int unsigned WIDTH = pgr_pkg::TEMP_W,
	parameter int unsigned AW    = $clog2(DEPTH)
)(
	input  wire logic             ref_clk_in,
	input  wire logic             rst_in,
	input  wire logic             wr_en_in,
	input  wire logic [AW-1:0]    wr_addr_in,
	input  wire logic [WIDTH-1:0] wr_data_in,
	input  wire logic [AW-1:0]    rd_addr_in,
	output logic      [WIDTH-1:0] rd_data_out
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [WIDTH-1:0]            rd;
	} pgr_mem_state_t;

	pgr_mem_state_t st_q;
	pgr_mem_state_t st_d;

	always_comb
	begin
		st_d = st_q;
		if (wr_en_in)
		begin
			st_d.mem[wr_addr_in] = wr_data_in;
		end
		// Read is registered from the stored table, so a write is seen by a read one cycle later
		st_d.rd = st_q.mem[rd_addr_in];
	end

	always_ff @(posedge ref_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			st_q <= '0;
		end
		else
		begin
			st_q <= st_d;
		end
	end

	assign rd_data_out = st_q.rd;

endmodule

// >>> src/pgr_power_reset_trip.sv
`timescale 1ns/100ps
module pgr_power_reset_trip #(
	parameter int unsigned MODS = pgr_pkg::MOD_COUNT,
	parameter int unsigned TW   = pgr_pkg::TEMP_W,
	parameter int unsigned AW   = $clog2(MODS)
)(
	input  wire logic          ref_clk_in,
	input  wire logic          rst_in,
	input  wire logic          power_good_in,
	input  wire logic          global_reset_in_n,
	input  wire logic          junction_hot_in,
	input  wire logic          mod_temp_valid_in,
	input  wire logic [AW-1:0] mod_temp_index_in,
	input  wire logic [TW-1:0] mod_temp_value_in,
	input  wire logic [TW-1:0] mod_crit_limit_in,
	output logic               thermal_trip_out_n,
	output logic               halt_exec_out,
	output logic               pll_shutdown_out,
	output logic               core_reset_out,
	output logic               cache_invalidate_out,
	output logic               sticky_reset_out,
	output logic               trip_cause_junction_out,
	output logic               trip_cause_memory_out
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic            pg_s1;
		logic            pg_s2;
		logic            rstn_s1;
		logic            rstn_s2;
		logic [MODS-1:0] mod_seen;
		logic [AW-1:0]   scan_idx;
		logic            scan_vld;
		logic            trip_n;
		logic            halt;
		logic            pll_off;
		logic            core_rst;
		logic            inval;
		logic            sticky_rst;
		logic            cause_junc;
		logic            cause_mem;
	} pgr_state_t;

	pgr_state_t    st_q;
	pgr_state_t    st_d;
	logic [TW-1:0] mod_rd_data;

	// ----------------------------------------
	// Module temperature table
	// ----------------------------------------
	pgr_temp_mem #(
		.DEPTH (MODS),
		.WIDTH (TW),
		.AW    (AW)
	) u_temp_mem (
		.ref_clk_in  (ref_clk_in),
		.rst_in      (rst_in),
		.wr_en_in    (mod_temp_valid_in),
		.wr_addr_in  (mod_temp_index_in),
		.wr_data_in  (mod_temp_value_in),
		.rd_addr_in  (st_q.scan_idx),
		.rd_data_out (mod_rd_data)
	);

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	logic pg_ok;
	logic reset_asserted;
	logic mem_hot;

	always_comb
	begin
		st_d           = st_q;
		pg_ok          = 1'b0;
		reset_asserted = 1'b0;
		mem_hot        = 1'b0;

		// ----------------------------------------
		// Pin synchronisers
		// ----------------------------------------
		// Pins from the platform, two flops before use
		st_d.pg_s1   = power_good_in;
		st_d.pg_s2   = st_q.pg_s1;
		st_d.rstn_s1 = global_reset_in_n;
		st_d.rstn_s2 = st_q.rstn_s1;

		// ----------------------------------------
		// Reset decode
		// ----------------------------------------
		// only a settled high level counts as good
		pg_ok = st_q.pg_s2;
		reset_asserted = ~st_q.rstn_s2 | ~pg_ok;

		// core state held, caches dropped unwritten
		st_d.core_rst = reset_asserted;
		st_d.inval    = reset_asserted;
		st_d.sticky_rst = ~pg_ok;

		// ----------------------------------------
		// Module scan
		// ----------------------------------------
		// Only entries the link has filled are trusted
		if (mod_temp_valid_in)
		begin
			st_d.mod_seen[mod_temp_index_in] = 1'b1;
		end

		// Round robin over the modules, one per cycle
		if (st_q.scan_idx == AW'(MODS - 1))
		begin
			st_d.scan_idx = '0;
		end
		else
		begin
			st_d.scan_idx = st_q.scan_idx + AW'(1);
		end
		st_d.scan_vld = st_q.mod_seen[st_q.scan_idx];

		// module over firmware critical limit
		// Unwritten entries stay untrusted and never trip
		mem_hot = st_q.scan_vld && (mod_rd_data > mod_crit_limit_in);

		// ----------------------------------------
		// Trip latch
		// ----------------------------------------
		// A hot sensor during reset is ignored; release re-arms
		// reset clears the latch, nothing sets it meanwhile
		if (reset_asserted)
		begin
			st_d.trip_n     = 1'b1;
			st_d.cause_junc = 1'b0;
			st_d.cause_mem  = 1'b0;
		end
		else
		begin
			if (junction_hot_in)
			begin
				st_d.trip_n     = 1'b0;
				st_d.cause_junc = 1'b1;
			end
			if (mem_hot)
			begin
				st_d.trip_n    = 1'b0;
				st_d.cause_mem = 1'b1;
			end
		end

		// ----------------------------------------
		// Trip consequences
		// ----------------------------------------
		// halt and stop PLLs while tripped
		st_d.halt    = ~st_d.trip_n;
		st_d.pll_off = ~st_d.trip_n;
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge ref_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			st_q            <= '0;
			st_q.pg_s1      <= pgr_pkg::SYNC_RST_VAL;
			st_q.pg_s2      <= pgr_pkg::SYNC_RST_VAL;
			st_q.rstn_s1    <= pgr_pkg::SYNC_RST_VAL;
			st_q.rstn_s2    <= pgr_pkg::SYNC_RST_VAL;
			st_q.mod_seen   <= {MODS{pgr_pkg::SEEN_RST_VAL}};
			st_q.scan_idx   <= AW'(pgr_pkg::SCAN_START);
			st_q.scan_vld   <= pgr_pkg::SEEN_RST_VAL;
			st_q.trip_n     <= pgr_pkg::TRIP_N_RST_VAL;
			st_q.halt       <= pgr_pkg::HALT_RST_VAL;
			st_q.pll_off    <= pgr_pkg::PLL_OFF_RST_VAL;
			st_q.core_rst   <= pgr_pkg::CORE_RST_RST_VAL;
			st_q.inval      <= pgr_pkg::INVAL_RST_VAL;
			st_q.sticky_rst <= pgr_pkg::STICKY_RST_RST_VAL;
			st_q.cause_junc <= pgr_pkg::CAUSE_RST_VAL;
			st_q.cause_mem  <= pgr_pkg::CAUSE_RST_VAL;
		end
		else
		begin
			st_q <= st_d;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// trip output is active low
	assign thermal_trip_out_n      = st_q.trip_n;
	// Platform cuts supplies on seeing the trip pin
	assign halt_exec_out           = st_q.halt;
	assign pll_shutdown_out        = st_q.pll_off;
	assign core_reset_out          = st_q.core_rst;
	assign cache_invalidate_out    = st_q.inval;
	assign sticky_reset_out        = st_q.sticky_rst;
	assign trip_cause_junction_out = st_q.cause_junc;
	assign trip_cause_memory_out   = st_q.cause_mem;

endmodule

// >>> test/pgr_prt_asserts.sv
`timescale 1ns/100ps
module pgr_prt_asserts #(
	parameter int unsigned MODS = 8,
	parameter int unsigned TW   = 8
)(
	input wire logic          ref_clk_in,
	input wire logic          rst_in,
	input wire logic          power_good_in,
	input wire logic          global_reset_in_n,
	input wire logic          junction_hot_in,
	input wire logic          mod_temp_valid_in,
	input wire logic [TW-1:0] mod_temp_value_in,
	input wire logic [TW-1:0] mod_crit_limit_in,
	input wire logic          thermal_trip_out_n,
	input wire logic          halt_exec_out,
	input wire logic          pll_shutdown_out,
	input wire logic          core_reset_out,
	input wire logic          cache_invalidate_out,
	input wire logic          sticky_reset_out
);
	// Memory write flop, read flop plus the output flop
	localparam int ML = MODS + 3;
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (rst_in);
	sequence s_run;
		(global_reset_in_n && power_good_in)[*3];
	endsequence
	sequence s_hot_wr;
		mod_temp_valid_in && (mod_temp_value_in > mod_crit_limit_in);
	endsequence
	property p_reset;
		!global_reset_in_n[*3] |=> core_reset_out && cache_invalidate_out;
	endproperty
	property p_sticky;
		power_good_in[*3] |=> !sticky_reset_out;
	endproperty
	property p_junc;
		s_run ##0 junction_hot_in |=> !thermal_trip_out_n;
	endproperty
	// Reset, limit change or rewrite may cancel the trip
	property p_mem;
		s_run ##0 s_hot_wr |-> ##[1:ML] (!thermal_trip_out_n || !global_reset_in_n
			|| !power_good_in || mod_temp_valid_in || $changed(mod_crit_limit_in));
	endproperty
	property p_halt;
		halt_exec_out == !thermal_trip_out_n && pll_shutdown_out == !thermal_trip_out_n;
	endproperty
	property p_latch;
		s_run ##0 !thermal_trip_out_n |=> !thermal_trip_out_n;
	endproperty
	property p_clear;
		!global_reset_in_n[*4] |-> thermal_trip_out_n;
	endproperty
	property p_retrip;
		!global_reset_in_n ##1 (s_run ##0 junction_hot_in[*3]) |=> !thermal_trip_out_n;
	endproperty
	a_reset: assert property (p_reset) else $error("core reset missing");
	a_sticky: assert property (p_sticky) else $error("sticky reset wrong");
	a_junc: assert property (p_junc) else $error("junction trip missing");
	a_mem: assert property (p_mem) else $error("memory trip missing");
	a_halt: assert property (p_halt) else $error("halt or pll wrong");
	a_latch: assert property (p_latch) else $error("trip not latched");
	a_clear: assert property (p_clear) else $error("trip not cleared");
	a_retrip: assert property (p_retrip) else $error("no trip after reset");
endmodule
bind pgr_power_reset_trip pgr_prt_asserts #(.MODS(MODS), .TW(TW)) u_chk (.*);

// >>> test/pgr_plat_model.sv
`timescale 1ns/100ps
module pgr_plat_model (
	input  wire logic drop_in,
	input  wire logic ref_clk_in,
	input  wire logic req_in,
	input  wire logic rst_in,
	input  wire logic trip_in_n,
	output logic      gr_out_n,
	output logic      pg_out,
	output logic      supply_off_out
);
	logic [2:0] settle_q;
	always_ff @(posedge ref_clk_in or posedge rst_in)
		if (rst_in)
		begin
			settle_q <= 3'h0;
			pg_out   <= 1'h0;
			gr_out_n <= 1'h0;
			supply_off_out <= 1'h0;
		end
		else
		begin
			settle_q <= drop_in ? 3'h0 : settle_q + {2'h0, settle_q != 3'h4};
			pg_out   <= !drop_in && settle_q == 3'h4;
			gr_out_n <= !req_in;
			// supplies cut once the trip is seen
			supply_off_out <= drop_in ? 1'h0 : (supply_off_out | !trip_in_n);
		end
endmodule

// >>> test/pgr_power_reset_trip_tb.sv
`timescale 1ns/100ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_count++; $display("Error %0t mismatch", $time); end end
module pgr_power_reset_trip_tb;
	logic       ref_clk_in = 1'h0, rst_in = 1'h1, junction_hot_in = 1'h0;
	logic       mod_temp_valid_in = 1'h0, drop = 1'h0, req = 1'h0;
	logic [2:0] mod_temp_index_in = 3'h0;
	logic [7:0] mod_temp_value_in = 8'h00, mod_crit_limit_in = 8'h80, lim;
	logic       power_good_in, global_reset_in_n, thermal_trip_out_n, halt_exec_out;
	logic       pll_shutdown_out, core_reset_out, cache_invalidate_out, sticky_reset_out;
	logic       trip_cause_junction_out, trip_cause_memory_out, supply_off;
	int         err_count = 0, checked = 0, seed = 18, cyc = 0;
	pgr_power_reset_trip DUT (.*);
	pgr_plat_model PLAT (.ref_clk_in, .rst_in, .drop_in(drop), .req_in(req),
		.pg_out(power_good_in), .gr_out_n(global_reset_in_n),
		.trip_in_n(thermal_trip_out_n), .supply_off_out(supply_off));
	initial
		forever #12.5 ref_clk_in = ~ref_clk_in;
	task automatic finish_test();
		if (err_count == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic wait_n(input int n);
		repeat (n) @(negedge ref_clk_in);
	endtask
	// Caller drops the strobe after the last write
	task automatic wr(input logic [2:0] i, input logic [7:0] v);
		mod_temp_index_in = i;
		mod_temp_value_in = v;
		mod_temp_valid_in = 1'h1;
		wait_n(1);
	endtask
	function automatic logic exp_trip(input logic [7:0] v, input logic [7:0] l);
		return v > l;
	endfunction
	always @(posedge ref_clk_in)
	begin
		cyc++;
		if (cyc > 2000)
		begin
			err_count++;
			finish_test();
		end
	end
	initial
	begin
		wait_n(6);
		rst_in = 1'h0;
		wait_n(12);
		`CHK({core_reset_out, sticky_reset_out, thermal_trip_out_n}, 3'h1)
		`CHK(supply_off, 1'h0)
		junction_hot_in = 1'h1;
		wait_n(1);
		junction_hot_in = 1'h0;
		`CHK({thermal_trip_out_n, halt_exec_out, pll_shutdown_out, trip_cause_junction_out}, 4'h7)
		wait_n(5);
		`CHK({thermal_trip_out_n, halt_exec_out, pll_shutdown_out}, 3'h3)
		`CHK(supply_off, 1'h1)
		junction_hot_in = 1'h1;
		req = 1'h1;
		wait_n(6);
		`CHK({thermal_trip_out_n, cache_invalidate_out, sticky_reset_out}, 3'h6)
		req = 1'h0;
		wait_n(6);
		`CHK({thermal_trip_out_n, core_reset_out}, 2'h0)
		junction_hot_in = 1'h0;
		req = 1'h1;
		wait_n(6);
		req = 1'h0;
		wait_n(6);
		lim = 8'h40 + 8'($unsigned($random(seed)) % 128);
		mod_crit_limit_in = lim;
		for (int i = 0; i < 8; i++)
			wr(3'(i), (i == 0) ? lim : lim - 8'($unsigned($random(seed)) % 64));
		mod_temp_valid_in = 1'h0;
		wait_n(12);
		`CHK(thermal_trip_out_n, !exp_trip(lim, lim))
		wr(3'($random(seed)), lim + 8'h01);
		mod_temp_valid_in = 1'h0;
		wait_n(12);
		`CHK({thermal_trip_out_n, trip_cause_memory_out}, {!exp_trip(lim + 8'h01, lim), 1'h1})
		drop = 1'h1;
		wait_n(10);
		`CHK({thermal_trip_out_n, core_reset_out, sticky_reset_out}, 3'h7)
		drop = 1'h0;
		wait_n(12);
		`CHK({core_reset_out, sticky_reset_out}, 2'h0)
		finish_test();
	end
endmodule
